// ---- logic/adtr_pkg.sv ----
// adtr_pkg: register map, field layout and reset values of the trim bank
package adtr_pkg;
  // ***************************************************
  // bus geometry
  // ***************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;

  // ***************************************************
  // register indices, byte address is four times the index
  // ***************************************************
  localparam logic [IDX_W-1:0] IDX_A_INA = 10'h348;
  localparam logic [IDX_W-1:0] IDX_A_INB = 10'h34A;
  localparam logic [IDX_W-1:0] IDX_B_INA = 10'h34C;
  localparam logic [IDX_W-1:0] IDX_B_INB = 10'h34E;
  localparam logic [IDX_W-1:0] IDX_G0 = 10'h350;
  localparam logic [IDX_W-1:0] IDX_G1 = 10'h351;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h3F0;
  localparam logic [IDX_W-1:0] IDX_STAT = 10'h3F1;

  // ***************************************************
  // field layout
  // ***************************************************
  localparam int OFS_W = 12;
  localparam int OFS_REG_W = 16;
  localparam int GAIN_W = 5;
  localparam int GAIN_REG_W = 8;
  localparam int CTRL_FGCAL_BIT = 0;
  localparam int CTRL_DUAL_BIT = 1;
  localparam int CTRL_RELOAD_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [OFS_REG_W-1:0] OFS_RST = 16'h0000;
  localparam logic [GAIN_REG_W-1:0] GAIN_RST = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ***************************************************
  // fuse storage slots
  // ***************************************************
  localparam int FUSE_AW = 3;
  localparam logic [FUSE_AW-1:0] SLOT_A_INA = 3'h0;
  localparam logic [FUSE_AW-1:0] SLOT_A_INB = 3'h1;
  localparam logic [FUSE_AW-1:0] SLOT_B_INA = 3'h2;
  localparam logic [FUSE_AW-1:0] SLOT_B_INB = 3'h3;
  localparam logic [FUSE_AW-1:0] SLOT_G0 = 3'h4;
  localparam logic [FUSE_AW-1:0] SLOT_G1 = 3'h5;
  localparam logic [FUSE_AW-1:0] SLOT_LAST = 3'h5;
endpackage

// ---- logic/adtr_fuse_loader.sv ----
// adtr_fuse_loader: walks the fuse slots and hands each default to the bank
`timescale 1ns/1ps
module adtr_fuse_loader (
  input wire logic clk_sys_i,                              // system clock
  input wire logic srst_i,                                 // sync reset, high
  input wire logic start_i,                                // pulse: reload all slots
  input wire logic fuse_ack_i,                             // fuse word valid
  input wire logic [15:0] fuse_data_i,                     // fuse word
  output logic fuse_req_o,                                 // fuse read request
  output logic [adtr_pkg::FUSE_AW-1:0] fuse_addr_o,        // fuse slot
  output logic ld_vld_o,                                   // pulse: load default
  output logic [adtr_pkg::FUSE_AW-1:0] ld_idx_o,           // slot being loaded
  output logic [15:0] ld_data_o,                           // default value
  output logic busy_o,                                     // walk in progress
  output logic done_o                                      // walk completed
);
  typedef enum logic {ST_IDLE, ST_REQ} adtr_ld_state_t;

  typedef struct packed {
    adtr_ld_state_t state;
    logic [adtr_pkg::FUSE_AW-1:0] idx;
    logic req;
    logic ld_vld;
    logic [adtr_pkg::FUSE_AW-1:0] ld_idx;
    logic [15:0] ld_data;
    logic done;
  } adtr_ld_t;

  adtr_ld_t r;
  adtr_ld_t r_nxt;

  always_comb begin
    r_nxt = r;
    r_nxt.ld_vld = 1'b0;
    unique case (r.state)
      ST_IDLE: begin
        if (start_i) begin
          r_nxt.state = ST_REQ;
          r_nxt.idx = '0;
          r_nxt.req = 1'b1;
          r_nxt.done = 1'b0;
        end
      end
      ST_REQ: begin
        if (fuse_ack_i) begin
          r_nxt.ld_vld = 1'b1;
          r_nxt.ld_idx = r.idx;
          r_nxt.ld_data = fuse_data_i;
          if (r.idx == adtr_pkg::SLOT_LAST) begin
            r_nxt.state = ST_IDLE;
            r_nxt.req = 1'b0;
            r_nxt.done = 1'b1;
          end else begin
            r_nxt.idx = r.idx + 3'h1;
          end
        end
      end
    endcase
  end

  // walk starts by itself after reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r <= '{state: ST_REQ, idx: 3'h0, req: 1'b1, ld_vld: 1'b0,
             ld_idx: 3'h0, ld_data: 16'h0000, done: 1'b0};
    end else begin
      r <= r_nxt;
    end
  end

  assign fuse_req_o = r.req;
  assign fuse_addr_o = r.idx;
  assign ld_vld_o = r.ld_vld;
  assign ld_idx_o = r.ld_idx;
  assign ld_data_o = r.ld_data;
  assign busy_o = r.req;
  assign done_o = r.done;
endmodule

// ---- logic/adtr_trim_bank.sv ----
// adtr_trim_bank: offset and fine gain trim registers with trim selection
//
// How it works
// - core A single-mode input A uses its trim
// - core A input B, 90-degree phase uses 0x34A
// - core B input A uses 0x34C, any mode
// - core B input B uses 0x34E, any mode
// - dual mode bank 0 gain from 0x350 bits 4:0
// - dual mode bank 1 gain from 0x351 bits 4:0
// - core B offsets default from fuse storage
// - 0x34A defaults from fuse, always readable, writable
`timescale 1ns/1ps
module adtr_trim_bank (
  input wire logic clk_sys_i,                              // 125 MHz system clock
  input wire logic srst_i,                                 // sync reset, high
  input wire logic [adtr_pkg::ADDR_W-1:0] paddr_i,         // apb byte address
  input wire logic psel_i,                                 // apb select
  input wire logic penable_i,                              // apb access phase
  input wire logic pwrite_i,                               // apb write
  input wire logic [adtr_pkg::DATA_W-1:0] pwdata_i,        // apb write data
  input wire logic [3:0] pstrb_i,                          // apb byte strobes
  output logic [adtr_pkg::DATA_W-1:0] prdata_o,            // apb read data
  output logic pready_o,                                   // apb ready
  output logic pslverr_o,                                  // apb error
  input wire logic core_a_samp_inb_i,                      // core A samples second input
  input wire logic core_b_samp_inb_i,                      // core B samples second input
  input wire logic core_a_bank_i,                          // core A bank in use
  output logic fuse_req_o,                                 // fuse read request
  output logic [adtr_pkg::FUSE_AW-1:0] fuse_addr_o,        // fuse slot
  input wire logic fuse_ack_i,                             // fuse word valid
  input wire logic [15:0] fuse_data_i,                     // fuse word
  output logic [adtr_pkg::OFS_W-1:0] core_a_offset_o,      // applied core A offset
  output logic [adtr_pkg::OFS_W-1:0] core_b_offset_o,      // applied core B offset
  output logic [adtr_pkg::GAIN_W-1:0] core_a_gain_o,       // applied core A fine gain
  output logic trim_active_o                               // calibration trims applied
);
  // ***************************************************
  // state
  // ***************************************************
  typedef struct packed {
    logic [adtr_pkg::OFS_REG_W-1:0] core_a_offset_single_ina;
    logic [adtr_pkg::OFS_REG_W-1:0] core_a_offset_single_inb;
    logic [adtr_pkg::OFS_REG_W-1:0] core_b_offset_ina;
    logic [adtr_pkg::OFS_REG_W-1:0] core_b_offset_inb;
    logic [adtr_pkg::GAIN_REG_W-1:0] core_a_bank0_fine_gain_dual;
    logic [adtr_pkg::GAIN_REG_W-1:0] core_a_bank1_fine_gain_dual;
    logic fgcal;
    logic dual;
    logic reload;
    logic pready;
    logic pslverr;
    logic [adtr_pkg::DATA_W-1:0] prdata;
    logic [adtr_pkg::OFS_W-1:0] a_ofs;
    logic [adtr_pkg::OFS_W-1:0] b_ofs;
    logic [adtr_pkg::GAIN_W-1:0] a_gain;
    logic trim_active;
  } adtr_state_t;

  adtr_state_t s_r;
  adtr_state_t s_nxt;

  logic ld_vld;
  logic [adtr_pkg::FUSE_AW-1:0] ld_idx;
  logic [15:0] ld_data;
  logic ld_busy;
  logic ld_done;
  logic setup;
  logic wr_acc;
  logic [adtr_pkg::IDX_W-1:0] idx;

  // ***************************************************
  // fuse default loader
  // ***************************************************
  adtr_fuse_loader u_loader (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .start_i(s_r.reload),
    .fuse_ack_i(fuse_ack_i),
    .fuse_data_i(fuse_data_i),
    .fuse_req_o(fuse_req_o),
    .fuse_addr_o(fuse_addr_o),
    .ld_vld_o(ld_vld),
    .ld_idx_o(ld_idx),
    .ld_data_o(ld_data),
    .busy_o(ld_busy),
    .done_o(ld_done)
  );

  // byte lane merge for the 16-bit offset registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  assign idx = paddr_i[adtr_pkg::ADDR_W-1:2];
  assign setup = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && s_r.pready && pwrite_i && !s_r.pslverr;

  // ***************************************************
  // next state
  // ***************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.reload = 1'b0;
    s_nxt.pready = setup;
    s_nxt.pslverr = 1'b0;
    // read data captured in setup so it leaves a flip-flop in access
    if (setup) begin
      s_nxt.prdata = adtr_pkg::RDATA_RST;
      unique case (idx)
        adtr_pkg::IDX_A_INA: s_nxt.prdata[15:0] = s_r.core_a_offset_single_ina;
        adtr_pkg::IDX_A_INB: s_nxt.prdata[15:0] = s_r.core_a_offset_single_inb;
        adtr_pkg::IDX_B_INA: s_nxt.prdata[15:0] = s_r.core_b_offset_ina;
        adtr_pkg::IDX_B_INB: s_nxt.prdata[15:0] = s_r.core_b_offset_inb;
        adtr_pkg::IDX_G0: s_nxt.prdata[7:0] = s_r.core_a_bank0_fine_gain_dual;
        adtr_pkg::IDX_G1: s_nxt.prdata[7:0] = s_r.core_a_bank1_fine_gain_dual;
        adtr_pkg::IDX_CTRL: begin
          s_nxt.prdata[adtr_pkg::CTRL_FGCAL_BIT] = s_r.fgcal;
          s_nxt.prdata[adtr_pkg::CTRL_DUAL_BIT] = s_r.dual;
        end
        adtr_pkg::IDX_STAT: begin
          s_nxt.prdata[adtr_pkg::STAT_BUSY_BIT] = ld_busy;
          s_nxt.prdata[adtr_pkg::STAT_DONE_BIT] = ld_done;
        end
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    // fuse defaults
    if (ld_vld) begin
      unique case (ld_idx)
        adtr_pkg::SLOT_A_INA: s_nxt.core_a_offset_single_ina = ld_data;
        adtr_pkg::SLOT_A_INB: s_nxt.core_a_offset_single_inb = ld_data;
        adtr_pkg::SLOT_B_INA: s_nxt.core_b_offset_ina = ld_data;
        adtr_pkg::SLOT_B_INB: s_nxt.core_b_offset_inb = ld_data;
        adtr_pkg::SLOT_G0: s_nxt.core_a_bank0_fine_gain_dual = ld_data[7:0];
        adtr_pkg::SLOT_G1: s_nxt.core_a_bank1_fine_gain_dual = ld_data[7:0];
        default: s_nxt.reload = 1'b0;
      endcase
    end
    // software write wins over a fuse load in the same cycle
    if (wr_acc) begin
      unique case (idx)
        adtr_pkg::IDX_A_INA: begin
          s_nxt.core_a_offset_single_ina =
            merge16(s_r.core_a_offset_single_ina, pwdata_i, pstrb_i);
        end
        adtr_pkg::IDX_A_INB: begin
          s_nxt.core_a_offset_single_inb =
            merge16(s_r.core_a_offset_single_inb, pwdata_i, pstrb_i);
        end
        adtr_pkg::IDX_B_INA: begin
          s_nxt.core_b_offset_ina = merge16(s_r.core_b_offset_ina, pwdata_i, pstrb_i);
        end
        adtr_pkg::IDX_B_INB: begin
          s_nxt.core_b_offset_inb = merge16(s_r.core_b_offset_inb, pwdata_i, pstrb_i);
        end
        adtr_pkg::IDX_G0: begin
          if (pstrb_i[0]) begin
            s_nxt.core_a_bank0_fine_gain_dual = pwdata_i[7:0];
          end
        end
        adtr_pkg::IDX_G1: begin
          if (pstrb_i[0]) begin
            s_nxt.core_a_bank1_fine_gain_dual = pwdata_i[7:0];
          end
        end
        adtr_pkg::IDX_CTRL: begin
          if (pstrb_i[0]) begin
            s_nxt.fgcal = pwdata_i[adtr_pkg::CTRL_FGCAL_BIT];
            s_nxt.dual = pwdata_i[adtr_pkg::CTRL_DUAL_BIT];
            s_nxt.reload = pwdata_i[adtr_pkg::CTRL_RELOAD_BIT];
          end
        end
        default: s_nxt.reload = s_nxt.reload;
      endcase
    end
    // ***************************************************
    // trim selection
    // ***************************************************
    s_nxt.trim_active = s_r.fgcal;
    s_nxt.a_ofs = '0;
    s_nxt.b_ofs = '0;
    if (s_r.fgcal && !s_r.dual) begin
      if (core_a_samp_inb_i) begin
        s_nxt.a_ofs = s_r.core_a_offset_single_inb[adtr_pkg::OFS_W-1:0];
      end else begin
        s_nxt.a_ofs = s_r.core_a_offset_single_ina[adtr_pkg::OFS_W-1:0];
      end
    end
    if (s_r.fgcal) begin
      if (core_b_samp_inb_i) begin
        s_nxt.b_ofs = s_r.core_b_offset_inb[adtr_pkg::OFS_W-1:0];
      end else begin
        s_nxt.b_ofs = s_r.core_b_offset_ina[adtr_pkg::OFS_W-1:0];
      end
    end
    s_nxt.a_gain = '0;
    if (s_r.dual) begin
      if (core_a_bank_i) begin
        s_nxt.a_gain = s_r.core_a_bank1_fine_gain_dual[adtr_pkg::GAIN_W-1:0];
      end else begin
        s_nxt.a_gain = s_r.core_a_bank0_fine_gain_dual[adtr_pkg::GAIN_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      s_r <= '{core_a_offset_single_ina: adtr_pkg::OFS_RST,
               core_a_offset_single_inb: adtr_pkg::OFS_RST,
               core_b_offset_ina: adtr_pkg::OFS_RST,
               core_b_offset_inb: adtr_pkg::OFS_RST,
               core_a_bank0_fine_gain_dual: adtr_pkg::GAIN_RST,
               core_a_bank1_fine_gain_dual: adtr_pkg::GAIN_RST,
               fgcal: 1'b0, dual: 1'b0, reload: 1'b0, pready: 1'b0, pslverr: 1'b0,
               prdata: adtr_pkg::RDATA_RST, a_ofs: 12'h000, b_ofs: 12'h000,
               a_gain: 5'h00, trim_active: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_o = s_r.prdata;
  assign pready_o = s_r.pready;
  assign pslverr_o = s_r.pslverr;
  assign core_a_offset_o = s_r.a_ofs;
  assign core_b_offset_o = s_r.b_ofs;
  assign core_a_gain_o = s_r.a_gain;
  assign trim_active_o = s_r.trim_active;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  sequence s_setup_at(logic [adtr_pkg::IDX_W-1:0] at);
    psel_i && !penable_i && idx == at;
  endsequence

  sequence s_fuse_b_ina;
    ld_vld && ld_idx == adtr_pkg::SLOT_B_INA && !wr_acc;
  endsequence

  a_core_a_ina: assert property (
    s_r.fgcal && !s_r.dual && !core_a_samp_inb_i |=>
      core_a_offset_o == $past(s_r.core_a_offset_single_ina[11:0]))
    else $error("core A input A offset not applied");

  a_core_a_inb: assert property (
    s_r.fgcal && !s_r.dual && core_a_samp_inb_i |=>
      core_a_offset_o == $past(s_r.core_a_offset_single_inb[11:0]))
    else $error("core A input B offset not applied");

  a_core_b_ina: assert property (
    s_r.fgcal && !core_b_samp_inb_i |=> core_b_offset_o == $past(s_r.core_b_offset_ina[11:0]))
    else $error("core B input A offset not applied");

  a_core_b_inb: assert property (
    s_r.fgcal && core_b_samp_inb_i |=> core_b_offset_o == $past(s_r.core_b_offset_inb[11:0]))
    else $error("core B input B offset not applied");

  a_bank0_gain: assert property (
    s_r.dual && !core_a_bank_i |=>
      core_a_gain_o == $past(s_r.core_a_bank0_fine_gain_dual[4:0]))
    else $error("bank 0 gain not applied");

  a_bank1_gain: assert property (
    s_r.dual && core_a_bank_i |=>
      core_a_gain_o == $past(s_r.core_a_bank1_fine_gain_dual[4:0]))
    else $error("bank 1 gain not applied");

  a_fuse_b_load: assert property (
    s_fuse_b_ina |=> s_r.core_b_offset_ina == $past(ld_data))
    else $error("fuse default not loaded into core B register");

  a_inb_readback: assert property (
    s_setup_at(adtr_pkg::IDX_A_INB) |=>
      pready_o && !pslverr_o && prdata_o == {16'h0000, $past(s_r.core_a_offset_single_inb)})
    else $error("core A input B register read back wrong");

  a_cal_off_zero: assert property (
    !s_r.fgcal |=> core_a_offset_o == 12'h000 && core_b_offset_o == 12'h000 && !trim_active_o)
    else $error("offset trim applied without calibration");

  a_unmapped_err: assert property (
    psel_i && !penable_i && idx == 10'h000 |=> pready_o && pslverr_o ##1 !pready_o)
    else $error("unmapped access not refused");

  sequence s_wr_full(logic [adtr_pkg::IDX_W-1:0] at);
    wr_acc && idx == at && pstrb_i[1:0] == 2'h3;
  endsequence

  sequence s_wr_lane0(logic [adtr_pkg::IDX_W-1:0] at);
    wr_acc && idx == at && pstrb_i[0];
  endsequence

  sequence s_fuse_at(logic [adtr_pkg::FUSE_AW-1:0] slot);
    ld_vld && ld_idx == slot && !wr_acc;
  endsequence

  a_b_ina_write: assert property (
    s_wr_full(adtr_pkg::IDX_B_INA) |=> s_r.core_b_offset_ina == $past(pwdata_i[15:0]))
    else $error("core B input A register write lost");

  a_b_inb_write: assert property (
    s_wr_full(adtr_pkg::IDX_B_INB) |=> s_r.core_b_offset_inb == $past(pwdata_i[15:0]))
    else $error("core B input B register write lost");

  a_inb_write: assert property (
    s_wr_full(adtr_pkg::IDX_A_INB) |=> s_r.core_a_offset_single_inb == $past(pwdata_i[15:0]))
    else $error("core A input B register write lost");

  a_g0_write: assert property (
    s_wr_lane0(adtr_pkg::IDX_G0) |=> s_r.core_a_bank0_fine_gain_dual == $past(pwdata_i[7:0]))
    else $error("bank 0 gain register write lost");

  a_g1_write: assert property (
    s_wr_lane0(adtr_pkg::IDX_G1) |=> s_r.core_a_bank1_fine_gain_dual == $past(pwdata_i[7:0]))
    else $error("bank 1 gain register write lost");

  a_fuse_b_inb: assert property (
    s_fuse_at(adtr_pkg::SLOT_B_INB) |=> s_r.core_b_offset_inb == $past(ld_data))
    else $error("fuse default not loaded into core B input B register");

  a_fuse_a_inb: assert property (
    s_fuse_at(adtr_pkg::SLOT_A_INB) |=> s_r.core_a_offset_single_inb == $past(ld_data))
    else $error("fuse default not loaded into core A input B register");

  a_gain_single_zero: assert property (
    !s_r.dual |=> core_a_gain_o == 5'h00)
    else $error("fine gain applied outside dual mode");

  a_dual_a_zero: assert property (
    s_r.dual |=> core_a_offset_o == 12'h000)
    else $error("core A single mode trim applied in dual mode");

  a_err_with_ready: assert property (
    pslverr_o |-> pready_o)
    else $error("error raised without ready");

  a_reload_pulse: assert property (
    s_r.reload |=> !s_r.reload)
    else $error("reload request not self clearing");
endmodule

// ---- verification/adtr_trim_bank_bench.sv ----
// adtr_trim_bank_bench: self-checking bench for the trim register bank
`timescale 1ns/1ps
module adtr_trim_bank_bench;
  typedef struct packed {
    logic err;
    logic chk;
    logic [31:0] data;
  } adtr_note_t;
  localparam logic [11:0] A_CTRL = {adtr_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_STAT = {adtr_pkg::IDX_STAT, 2'h0};
  logic clk_sys_i = 1'h0;
  logic srst_i = 1'h1;
  logic [11:0] paddr_i = 12'h000;
  logic psel_i = 1'h0;
  logic penable_i = 1'h0;
  logic pwrite_i = 1'h0;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0] pstrb_i = 4'hF;
  logic core_a_samp_inb_i = 1'h0;
  logic core_b_samp_inb_i = 1'h0;
  logic core_a_bank_i = 1'h0;
  logic fuse_ack_i = 1'h0;
  logic [15:0] fuse_data_i = 16'h0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic fuse_req_o;
  logic [2:0] fuse_addr_o;
  logic [11:0] core_a_offset_o;
  logic [11:0] core_b_offset_o;
  logic [4:0] core_a_gain_o;
  logic trim_active_o;
  adtr_note_t notes[$];
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic fuse_en = 1'h0;
  logic seen_r = 1'h0;
  logic [2:0] last_r = 3'h0;
  logic [15:0] fuse_val [6];
  logic [15:0] sh [6];
  logic [9:0] idx [6];

  always #4 clk_sys_i = ~clk_sys_i;

  adtr_trim_bank adtr_trim_bank_i (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .core_a_samp_inb_i(core_a_samp_inb_i), .core_b_samp_inb_i(core_b_samp_inb_i),
    .core_a_bank_i(core_a_bank_i), .fuse_req_o(fuse_req_o), .fuse_addr_o(fuse_addr_o),
    .fuse_ack_i(fuse_ack_i), .fuse_data_i(fuse_data_i), .core_a_offset_o(core_a_offset_o),
    .core_b_offset_o(core_b_offset_o), .core_a_gain_o(core_a_gain_o),
    .trim_active_o(trim_active_o)
  );

  // ***************************************************
  // reporting
  // ***************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  // ***************************************************
  // fuse storage: random stalls, one ack per slot
  // ***************************************************
  always @(posedge clk_sys_i) begin
    if (srst_i || !fuse_en) begin
      fuse_ack_i <= 1'h0;
      seen_r <= 1'h0;
      fuse_data_i <= ~fuse_data_i;
    end else if (fuse_ack_i) begin
      fuse_ack_i <= 1'h0;
      seen_r <= 1'h1;
      last_r <= fuse_addr_o;
      fuse_data_i <= ~fuse_data_i;
    end else if (fuse_req_o && !(seen_r && fuse_addr_o == last_r) && $urandom_range(1, 0)) begin
      fuse_ack_i <= 1'h1;
      fuse_data_i <= fuse_val[fuse_addr_o];
    end else begin
      fuse_data_i <= ~fuse_data_i;
    end
  end

  // ***************************************************
  // apb answer monitor: oldest note per completed transfer
  // ***************************************************
  always @(posedge clk_sys_i) begin
    adtr_note_t nt;
    if (psel_i && penable_i && pready_o === 1'h1) begin
      if (notes.size() == 0) begin
        check("note_queue", 32'h0, 32'h1);
      end else begin
        nt = notes.pop_front();
        check("pslverr", {31'h0, pslverr_o}, {31'h0, nt.err});
        if (nt.chk) begin
          check("prdata", prdata_o, nt.data);
        end
      end
    end
  end

  // ***************************************************
  // apb master tasks
  // ***************************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st, input adtr_note_t nt, output logic [31:0] rd);
    int n;
    notes.push_back(nt);
    @(posedge clk_sys_i);
    psel_i <= 1'h1;
    penable_i <= 1'h0;
    paddr_i <= a;
    pwrite_i <= wr;
    pwdata_i <= wd;
    pstrb_i <= st;
    @(posedge clk_sys_i);
    penable_i <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'h1 && n < 50);
    if (n >= 50) begin
      check("pready", {31'h0, pready_o}, 32'h1);
    end
    rd = prdata_o;
    psel_i <= 1'h0;
    penable_i <= 1'h0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] d;
    apb(1'h0, a, 32'h0, 4'hF, '{err, 1'h1, exp}, d);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic err);
    logic [31:0] d;
    apb(1'h1, a, wd, 4'hF, '{err, 1'h0, 32'h0}, d);
  endtask

  task automatic wr_reg(input int i, input logic [31:0] wd, input logic [3:0] st);
    logic [15:0] m;
    logic [31:0] d;
    m = {st[1] ? 8'hFF : 8'h00, st[0] ? 8'hFF : 8'h00};
    if (i >= 4) begin
      m[15:8] = 8'h00;
    end
    sh[i] = (sh[i] & ~m) | (wd[15:0] & m);
    apb(1'h1, {idx[i], 2'h0}, wd, st, '{1'h0, 1'h0, 32'h0}, d);
  endtask

  task automatic read_all;
    for (int i = 0; i < 6; i++) begin
      rd_chk({idx[i], 2'h0}, {16'h0, sh[i]}, 1'h0);
    end
  endtask

  task automatic fuse_walk;
    logic [31:0] d;
    int n;
    n = 0;
    d = 32'h0;
    while ((d[0] !== 1'h0 || d[1] !== 1'h1) && n < 200) begin
      apb(1'h0, A_STAT, 32'h0, 4'hF, '{1'h0, 1'h0, 32'h0}, d);
      n++;
    end
    for (int i = 0; i < 6; i++) begin
      sh[i] = (i >= 4) ? {8'h00, fuse_val[i][7:0]} : fuse_val[i];
    end
    read_all();
  endtask

  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    logic [11:0] ea;
    logic [11:0] eb;
    logic [4:0] eg;
    void'($urandom(39));
    idx = '{adtr_pkg::IDX_A_INA, adtr_pkg::IDX_A_INB, adtr_pkg::IDX_B_INA,
            adtr_pkg::IDX_B_INB, adtr_pkg::IDX_G0, adtr_pkg::IDX_G1};
    for (int i = 0; i < 6; i++) begin
      fuse_val[i] = 16'($urandom);
      sh[i] = 16'h0000;
    end
    repeat (12) @(posedge clk_sys_i);
    srst_i <= 1'h0;
    check("fuse_req", {31'h0, fuse_req_o}, 32'h1);
    read_all();
    rd_chk(A_CTRL, 32'h0, 1'h0);
    rd_chk(A_STAT, 32'h1, 1'h0);
    fuse_en <= 1'h1;
    fuse_walk();
    wr(A_STAT, 32'hFFFF_FFFF, 1'h0);
    rd_chk(A_STAT, 32'h2, 1'h0);
    rd_chk(12'h000, 32'h0, 1'h1);
    wr(12'h004, 32'h1234_5678, 1'h0 | 1'h1);
    wr_reg(2, $urandom, 4'h2);
    wr_reg(1, $urandom, 4'h1);
    wr_reg(5, $urandom, 4'hF);
    read_all();
    for (int i = 0; i < 6; i++) begin
      wr_reg(i, $urandom, 4'hF);
    end
    read_all();
    for (int i = 0; i < 6; i++) begin
      fuse_val[i] = 16'($urandom);
    end
    wr(A_CTRL, 32'h4, 1'h0);
    fuse_walk();
    rd_chk(A_CTRL, 32'h0, 1'h0);
    for (int k = 0; k < 32; k++) begin
      if (k >= 8) begin
        wr_reg(k % 6, $urandom, 4'hF);
      end
      wr(A_CTRL, {30'h0, k[1], k[0]}, 1'h0);
      @(posedge clk_sys_i);
      core_a_samp_inb_i <= k[2];
      core_b_samp_inb_i <= k[3];
      core_a_bank_i <= k[4];
      repeat (3) @(posedge clk_sys_i);
      ea = (k[0] && !k[1]) ? (k[2] ? sh[1][11:0] : sh[0][11:0]) : 12'h000;
      eb = k[0] ? (k[3] ? sh[3][11:0] : sh[2][11:0]) : 12'h000;
      eg = k[1] ? (k[4] ? sh[5][4:0] : sh[4][4:0]) : 5'h00;
      check("core_a_offset", {20'h0, core_a_offset_o}, {20'h0, ea});
      check("core_b_offset", {20'h0, core_b_offset_o}, {20'h0, eb});
      check("core_a_gain", {27'h0, core_a_gain_o}, {27'h0, eg});
      check("trim_active", {31'h0, trim_active_o}, {31'h0, k[0]});
    end
    stop_test();
  end
endmodule
